// file: rtl/bgp_pkg.sv
// Shared constants and types for the battery gauge parameter logic
package bgp_pkg;
   // ----------------------------------------
   // Parameter image layout
   // ----------------------------------------
   localparam int IMG_DEPTH = 128;
   localparam int IMG_AW = 7;
   localparam logic [6:0] ADDR_CHG_VOLT = 7'h0a;
   localparam logic [6:0] ADDR_DESIGN_VOLT = 7'h12;
   localparam logic [6:0] ADDR_FAST_CUR = 7'h1a;
   localparam logic [6:0] ADDR_MAINT_CUR = 7'h1c;
   localparam logic [6:0] ADDR_PRE_CUR = 7'h1e;
   localparam logic [6:0] ADDR_LIGHT_LOAD = 7'h2b;
   localparam logic [6:0] ADDR_LAST_DISCH = 7'h38;
   localparam logic [6:0] ADDR_PACK_CAP = 7'h3a;
   localparam logic [6:0] ADDR_PACK_CFG = 7'h3f;
   localparam logic [6:0] ADDR_OV_MARGIN = 7'h48;
   localparam logic [6:0] ADDR_BASE_EFF = 7'h4d;
   localparam logic [6:0] ADDR_FILTER = 7'h52;
   localparam logic [6:0] ADDR_SELF_DISCH = 7'h53;
   localparam logic [6:0] ADDR_BATT_LOW = 7'h54;
   localparam logic [6:0] ADDR_NEAR_FULL = 7'h55;
   localparam logic [6:0] ADDR_TEMP_EFF = 7'h63;
   localparam logic [6:0] ADDR_DROP_OFF = 7'h64;
   localparam logic [6:0] ADDR_RED_RATE = 7'h65;
   localparam logic [6:0] ADDR_MID_CHECK = 7'h6c;
   localparam logic [6:0] ADDR_EDV_LOW = 7'h72;
   localparam logic [6:0] ADDR_EDV_MID = 7'h74;
   localparam logic [6:0] ADDR_EDV_HIGH = 7'h78;
   localparam logic [6:0] ADDR_EDV_R0 = 7'h7a;
   localparam int CFG_CHEMISTRY_SELECT_BIT_BIT = 2;
   localparam int CFG_COMP_BIT = 4;
   localparam int C0_BITS = 11;
   // ----------------------------------------
   // Decode constants
   // ----------------------------------------
   localparam int FILTER_NUM = 2250;
   localparam int SELF_DISCH_NUM = 5273;
   localparam int LIGHT_LOAD_MUL = 45000;
   localparam int LIGHT_LOAD_SHIFT = 10;
   localparam int MWH_DIV = 10000;
   localparam int EFF_OFFSET = 745;
   localparam int EFF_TO_Q = 8;
   localparam int TEMP_NUM = 10;
   localparam int TEMP_DEN = 16;
   localparam int TEMP_REF_C = 25;
   localparam int OV_SHIFT = 4;
   localparam int PCT_SCALE = 100;
   localparam int PCT_SHIFT = 8;
   localparam int EDV_MID_PCT = 3;
   localparam int EDV_CAP_SPAN = 32;
   localparam int EDV_CAP_SHIFT = 3;
   localparam int EDV_R0_SHIFT = 16;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   typedef enum logic [0:0] {BGP_LD_SCAN, BGP_LD_DONE} bgp_load_e;
   typedef enum logic [0:0] {BGP_LEARN_IDLE, BGP_LEARN_ARMED} bgp_learn_e;
endpackage

// file: rtl/bgp_load_if.sv
// Parameter image write path between loader and gauge logic
`timescale 1ns/1ps
interface bgp_load_if;
   logic wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic done;
   modport loader (output wr_en, output wr_addr, output wr_data, output done);
   modport store (input wr_en, input wr_addr, input wr_data, input done);
endinterface

// file: rtl/bgp_loader.sv
// Reads the whole parameter image from nonvolatile memory after reset
`timescale 1ns/1ps
module bgp_loader
   import bgp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   output logic nvm_rd_req,
   output logic [6:0] nvm_addr,
   input wire logic [7:0] nvm_rd_data,
   input wire logic nvm_rd_ack,
   bgp_load_if.loader ld
);
   bgp_load_e state_reg;
   logic [6:0] idx_reg;

   // ----------------------------------------
   // Scan sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= BGP_LD_SCAN;
         idx_reg <= 7'h00;
      end
      else if (state_reg == BGP_LD_SCAN && nvm_rd_ack)
      begin
         idx_reg <= idx_reg + 7'h01;
         if (idx_reg == 7'(IMG_DEPTH - 1))
         begin
            state_reg <= BGP_LD_DONE;
         end
      end
   end

   assign nvm_rd_req = (state_reg == BGP_LD_SCAN);
   assign nvm_addr = idx_reg;
   assign ld.wr_en = (state_reg == BGP_LD_SCAN) && nvm_rd_ack;
   assign ld.wr_addr = idx_reg;
   assign ld.wr_data = nvm_rd_data;
   assign ld.done = (state_reg == BGP_LD_DONE);
endmodule

// file: rtl/bgp_gauge.sv
// Battery gauge parameter interpretation and charge control values
// What this block does
// RQ1: Filter threshold is 2250 over stored byte
// RQ2: Capacity in mAh mode copies pack capacity
// RQ3: Energy mode: capacity times voltage, 10mWh units
// RQ4: Learning rewrites last discharge; derives full capacity
// RQ5: Compensation off: end voltages taken as stored
// RQ6: Full capacity updates after near-full to highest
// RQ7: Near-full byte is half the window
// RQ8: Compensated end voltages at 0, 3, low%
// RQ9: Adjust factor low 11 bits, residual upper 5
// RQ10: Midrange checks are negated mV, test remaining
// RQ11: Self-discharge is 52.73 over negated byte
// RQ12: Light load byte is current times 1024/45
// RQ13: Reduction rate applies at or above drop-off
// RQ14: Base efficiency byte is ten times (eff-74.5)
// RQ15: Reduction per point above drop-off, 0.0125 steps
// RQ16: Temperature reduction above 25C, scaled 1.6/0.0125
// RQ17: Nickel uses four factors, lithium base only
// RQ18: Charging voltage reported, base for overvoltage
// RQ19: Suspend above charging voltage plus margin*16
// RQ20: Fast allowed requests fast charging current
// RQ21: Termination gives zero, then maintenance current
// RQ22: Below lowest end voltage requests pre-charge
// RQ23: Compensation bit selects computed end voltages
// RQ24: Chemistry bit set selects lithium-ion
// RQ25: Load parameters before reporting derived values
// RQ26: Current selection follows one fixed priority
`timescale 1ns/1ps
module bgp_gauge
   import bgp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   output logic nvm_rd_req,
   output logic [6:0] nvm_addr,
   input wire logic [7:0] nvm_rd_data,
   input wire logic nvm_rd_ack,
   input wire logic energy_mode,
   input wire logic [15:0] pack_voltage_mv,
   input wire logic signed [15:0] load_current_ma,
   input wire logic signed [7:0] temperature_c,
   input wire logic [7:0] relative_charge_pct,
   input wire logic [15:0] remaining_capacity,
   input wire logic [15:0] discharged_mah,
   input wire logic discharging,
   input wire logic charging,
   input wire logic fast_charge_allowed,
   input wire logic fast_charge_terminated,
   output logic params_loaded,
   output logic [15:0] filter_threshold_uv,
   output logic [15:0] design_capacity,
   output logic [15:0] full_charge_capacity,
   output logic full_capacity_update,
   output logic [15:0] end_voltage_lowest,
   output logic [15:0] end_voltage_middle,
   output logic [15:0] end_voltage_highest,
   output logic [2:0] midrange_mismatch,
   output logic [15:0] self_discharge_per_day,
   output logic [15:0] light_load_current,
   output logic [15:0] charge_efficiency,
   output logic [15:0] charging_voltage,
   output logic charge_suspend,
   output logic [15:0] charging_current
);
   bgp_load_if ld ();
   logic [7:0] image_reg [IMG_DEPTH];
   bgp_learn_e learn_reg;
   logic maint_reg, ov_next;
   logic chemistry_select_bit, voltage_comp_enable_bit;
   logic [15:0] emf_mv, r0_word, edv_word, last_disch_reg;
   logic [10:0] capacity_adjust_factor;
   logic [4:0] residual_capacity_factor;
   logic [7:0] cfg, batt_low_pct, near_full_window, drop_pct, neg_disch;
   logic [15:0] edv_low_next, edv_mid_next, edv_high_next, fcc_next, cur_next, eff_next;
   logic [2:0] mid_next;

   bgp_loader u_loader (
      .clk(clk),
      .reset(reset),
      .nvm_rd_req(nvm_rd_req),
      .nvm_addr(nvm_addr),
      .nvm_rd_data(nvm_rd_data),
      .nvm_rd_ack(nvm_rd_ack),
      .ld(ld.loader)
   );

   function automatic logic [15:0] word_at(input logic [7:0] lo, input logic [7:0] hi);
      word_at = {hi, lo};
   endfunction
   function automatic logic [15:0] comp_edv(input logic [15:0] emf, input logic [15:0] r0,
      input logic [15:0] i_abs, input logic [10:0] c0, input logic [7:0] cpct);
      int drop, span, v;
      drop = (int'(i_abs) * int'(r0)) >>> EDV_R0_SHIFT;
      span = (int'(cpct) >= EDV_CAP_SPAN) ? 0 : EDV_CAP_SPAN - int'(cpct);
      v = int'(emf) - drop - ((int'(c0) * span) >>> EDV_CAP_SHIFT);
      comp_edv = (v < 0) ? 16'h0000 : 16'(v);
   endfunction

   // ----------------------------------------
   // Parameter image
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < IMG_DEPTH; i++)
            image_reg[i] <= 8'h00;
      end
      else if (ld.wr_en)
         image_reg[ld.wr_addr] <= ld.wr_data; // RQ25
   end

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign cfg = image_reg[ADDR_PACK_CFG];
   assign chemistry_select_bit = cfg[CFG_CHEMISTRY_SELECT_BIT_BIT]; // RQ24
   assign voltage_comp_enable_bit = cfg[CFG_COMP_BIT];
   assign emf_mv = word_at(image_reg[ADDR_EDV_MID], image_reg[ADDR_EDV_MID + 7'h01]);
   assign edv_word = word_at(image_reg[ADDR_EDV_HIGH], image_reg[ADDR_EDV_HIGH + 7'h01]);
   assign r0_word = word_at(image_reg[ADDR_EDV_R0], image_reg[ADDR_EDV_R0 + 7'h01]);
   assign capacity_adjust_factor = edv_word[C0_BITS-1:0]; // RQ9
   assign residual_capacity_factor = edv_word[15:C0_BITS]; // RQ9
   assign batt_low_pct = 8'((int'(image_reg[ADDR_BATT_LOW]) * PCT_SCALE) >>> PCT_SHIFT);
   assign near_full_window = image_reg[ADDR_NEAR_FULL];
   assign drop_pct = 8'(-image_reg[ADDR_DROP_OFF]);
   assign neg_disch = 8'(-image_reg[ADDR_SELF_DISCH]);

   // ----------------------------------------
   // End-of-discharge thresholds
   // ----------------------------------------
   always_comb
   begin
      logic [15:0] i_abs;
      i_abs = load_current_ma[15] ? 16'(-load_current_ma) : 16'(load_current_ma);
      if (voltage_comp_enable_bit) // RQ23
      begin
         edv_low_next = comp_edv(emf_mv, r0_word, i_abs, capacity_adjust_factor,
            8'(residual_capacity_factor)); // RQ8
         edv_mid_next = comp_edv(emf_mv, r0_word, i_abs, capacity_adjust_factor,
            8'(EDV_MID_PCT + int'(residual_capacity_factor))); // RQ8
         edv_high_next = comp_edv(emf_mv, r0_word, i_abs, capacity_adjust_factor,
            8'(int'(batt_low_pct) + int'(residual_capacity_factor))); // RQ8
      end
      else
      begin
         edv_low_next = word_at(image_reg[ADDR_EDV_LOW], image_reg[ADDR_EDV_LOW + 7'h01]); // RQ5
         edv_mid_next = emf_mv; // RQ5
         edv_high_next = edv_word; // RQ5
      end
   end

   // ----------------------------------------
   // Capacity learning
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         learn_reg <= BGP_LEARN_IDLE;
         last_disch_reg <= RESET_WORD;
         full_capacity_update <= 1'b0;
      end
      else
      begin
         full_capacity_update <= 1'b0;
         if (ld.wr_en && ld.wr_addr == ADDR_LAST_DISCH)
            last_disch_reg[7:0] <= ld.wr_data;
         else if (ld.wr_en && ld.wr_addr == ADDR_LAST_DISCH + 7'h01)
            last_disch_reg[15:8] <= ld.wr_data;
         else if (ld.done)
         begin
            unique case (learn_reg)
               BGP_LEARN_IDLE:
                  if (discharging && 17'(remaining_capacity) + 17'({near_full_window, 1'b0})
                     >= 17'(last_disch_reg)) // RQ7
                     learn_reg <= BGP_LEARN_ARMED;
               BGP_LEARN_ARMED:
                  if (charging)
                     learn_reg <= BGP_LEARN_IDLE;
                  else if (discharging && pack_voltage_mv < end_voltage_highest) // RQ6
                  begin
                     learn_reg <= BGP_LEARN_IDLE;
                     last_disch_reg <= discharged_mah; // RQ4
                     full_capacity_update <= 1'b1;
                  end
            endcase
         end
      end
   end
   assign fcc_next = energy_mode ? 16'((int'(last_disch_reg) * int'(word_at(image_reg[ADDR_DESIGN_VOLT],
      image_reg[ADDR_DESIGN_VOLT + 7'h01]))) / MWH_DIV) : last_disch_reg; // RQ4

   // ----------------------------------------
   // Midrange checks
   // ----------------------------------------
   for (genvar g = 0; g < 3; g++)
   begin : g_mid
      logic [15:0] voc;
      assign voc = 16'(-word_at(image_reg[ADDR_MID_CHECK + 7'(2 * g)],
         image_reg[ADDR_MID_CHECK + 7'(2 * g + 1)])); // RQ10
      assign mid_next[g] = (pack_voltage_mv >= voc) &&
         (int'(remaining_capacity) * 4 < int'(last_disch_reg) * (g + 1)); // RQ10
   end

   // ----------------------------------------
   // Charge efficiency and voltage limits
   // ----------------------------------------
   always_comb
   begin
      int eff;
      eff = (int'(image_reg[ADDR_BASE_EFF]) + EFF_OFFSET) * EFF_TO_Q; // RQ14
      if (!chemistry_select_bit) // RQ17
      begin
         if (relative_charge_pct >= drop_pct) // RQ13
            eff = eff - int'(image_reg[ADDR_RED_RATE]) * (int'(relative_charge_pct) - int'(drop_pct)); // RQ15
         if (int'(temperature_c) > TEMP_REF_C)
            eff = eff - (int'(image_reg[ADDR_TEMP_EFF]) * (int'(temperature_c) - TEMP_REF_C)
               * TEMP_NUM) / TEMP_DEN; // RQ16
      end
      eff_next = (eff < 0) ? 16'h0000 : 16'(eff);
   end
   assign ov_next = 17'(pack_voltage_mv) > 17'(word_at(image_reg[ADDR_CHG_VOLT], image_reg[ADDR_CHG_VOLT + 7'h01])) +
      (17'(image_reg[ADDR_OV_MARGIN]) << OV_SHIFT); // RQ19

   // ----------------------------------------
   // Charging current selection
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         maint_reg <= 1'b0;
      else if (fast_charge_terminated)
         maint_reg <= 1'b1; // RQ21
   end
   always_comb
   begin
      if (!ld.done || ov_next) // RQ26
         cur_next = 16'h0000; // RQ19
      else if (pack_voltage_mv < end_voltage_lowest)
         cur_next = word_at(image_reg[ADDR_PRE_CUR], image_reg[ADDR_PRE_CUR + 7'h01]); // RQ22
      else if (fast_charge_terminated)
         cur_next = 16'h0000; // RQ21
      else if (maint_reg)
         cur_next = word_at(image_reg[ADDR_MAINT_CUR], image_reg[ADDR_MAINT_CUR + 7'h01]); // RQ21
      else if (fast_charge_allowed)
         cur_next = word_at(image_reg[ADDR_FAST_CUR], image_reg[ADDR_FAST_CUR + 7'h01]); // RQ20
      else
         cur_next = 16'h0000;
   end

   // ----------------------------------------
   // Reported values
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         params_loaded <= 1'b0;
         filter_threshold_uv <= RESET_WORD;
         design_capacity <= RESET_WORD;
         full_charge_capacity <= RESET_WORD;
         end_voltage_lowest <= RESET_WORD;
         end_voltage_middle <= RESET_WORD;
         end_voltage_highest <= RESET_WORD;
         midrange_mismatch <= 3'h0;
         self_discharge_per_day <= RESET_WORD;
         light_load_current <= RESET_WORD;
         charge_efficiency <= RESET_WORD;
         charging_voltage <= RESET_WORD;
         charge_suspend <= 1'b0;
         charging_current <= RESET_WORD;
      end
      else if (ld.done) // RQ25
      begin
         params_loaded <= 1'b1;
         filter_threshold_uv <= (image_reg[ADDR_FILTER] == 8'h00) ? 16'hffff :
            16'(FILTER_NUM / int'(image_reg[ADDR_FILTER])); // RQ1
         design_capacity <= energy_mode ? 16'((int'(word_at(image_reg[ADDR_PACK_CAP],
            image_reg[ADDR_PACK_CAP + 7'h01])) * int'(word_at(image_reg[ADDR_DESIGN_VOLT],
            image_reg[ADDR_DESIGN_VOLT + 7'h01]))) / MWH_DIV) // RQ3
            : word_at(image_reg[ADDR_PACK_CAP], image_reg[ADDR_PACK_CAP + 7'h01]); // RQ2
         full_charge_capacity <= fcc_next; // RQ4
         end_voltage_lowest <= edv_low_next;
         end_voltage_middle <= edv_mid_next;
         end_voltage_highest <= edv_high_next;
         midrange_mismatch <= mid_next;
         self_discharge_per_day <= (neg_disch == 8'h00) ? 16'hffff :
            16'(SELF_DISCH_NUM / int'(neg_disch)); // RQ11
         light_load_current <= 16'((int'(image_reg[ADDR_LIGHT_LOAD]) * LIGHT_LOAD_MUL)
            >>> LIGHT_LOAD_SHIFT); // RQ12
         charge_efficiency <= eff_next;
         charging_voltage <= word_at(image_reg[ADDR_CHG_VOLT], image_reg[ADDR_CHG_VOLT + 7'h01]); // RQ18
         charge_suspend <= ov_next; // RQ19
         charging_current <= cur_next; // RQ20
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   no_early_report_a: assert property (!ld.done |=> !params_loaded && charging_current == 16'h0000) // RQ25
      else $error("Values reported before parameters loaded");
   filter_decode_a: assert property (ld.done && image_reg[ADDR_FILTER] != 8'h00 |=> // RQ1
      filter_threshold_uv == 16'(FILTER_NUM / int'($past(image_reg[ADDR_FILTER]))))
      else $error("Filter threshold decode wrong");
   mah_copy_a: assert property (ld.done && !energy_mode |=> // RQ2
      design_capacity == $past(word_at(image_reg[ADDR_PACK_CAP], image_reg[ADDR_PACK_CAP + 7'h01])))
      else $error("Design capacity not a copy");
   fixed_edv_a: assert property (ld.done && !voltage_comp_enable_bit |=> // RQ5
      end_voltage_highest == $past(edv_word) && end_voltage_middle == $past(emf_mv))
      else $error("Fixed end voltage not used");
   learn_update_a: assert property (full_capacity_update |-> // RQ6
      last_disch_reg == $past(discharged_mah) && $past(learn_reg) == BGP_LEARN_ARMED)
      else $error("Capacity learned without qualified discharge");
   lithium_eff_a: assert property (ld.done && chemistry_select_bit |=> // RQ17
      charge_efficiency == 16'((int'($past(image_reg[ADDR_BASE_EFF])) + EFF_OFFSET) * EFF_TO_Q))
      else $error("Lithium efficiency adjusted");
   ov_suspend_a: assert property (ld.done && ov_next |=> charge_suspend && charging_current == 16'h0000) // RQ19
      else $error("Overvoltage did not suspend charging");
   precharge_sel_a: assert property (ld.done && !ov_next && pack_voltage_mv < end_voltage_lowest |=> // RQ22
      charging_current == $past(word_at(image_reg[ADDR_PRE_CUR], image_reg[ADDR_PRE_CUR + 7'h01])))
      else $error("Pre-charge current not requested");
   term_zero_a: assert property (ld.done && !ov_next && pack_voltage_mv >= end_voltage_lowest // RQ21
      && fast_charge_terminated |=> charging_current == 16'h0000 ##1 maint_reg)
      else $error("Termination did not zero current");
   fast_sel_a: assert property (ld.done && !ov_next && pack_voltage_mv >= end_voltage_lowest // RQ20
      && !fast_charge_terminated && !maint_reg && fast_charge_allowed |=>
      charging_current == $past(word_at(image_reg[ADDR_FAST_CUR], image_reg[ADDR_FAST_CUR + 7'h01])))
      else $error("Fast charging current not requested");
   load_done_c: cover property (!params_loaded ##1 params_loaded);
   learn_cycle_c: cover property (learn_reg == BGP_LEARN_ARMED ##[1:1000] full_capacity_update);
   term_maint_c: cover property (fast_charge_terminated ##1 !fast_charge_terminated && maint_reg);
   suspend_c: cover property (charge_suspend);
endmodule

// file: tb/bgp_nvm_model.sv
// Parameter memory model that answers the gauge's byte reads
`timescale 1ns/1ps
module bgp_nvm_model
(
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic nvm_rd_req,
   input wire logic [6:0] nvm_addr,
   output logic [7:0] nvm_rd_data,
   output logic nvm_rd_ack
);
   logic [7:0] mem [0:127];
   logic [1:0] wait_reg;
   logic [7:0] last_reg;
   // Prompt answers in the request cycle, slow after two waits
   assign nvm_rd_ack = nvm_rd_req && (!slow || wait_reg == 2'h2);
   // Outside an answer the data lines show garbage
   assign nvm_rd_data = nvm_rd_ack ? mem[nvm_addr] : ~last_reg;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         wait_reg <= 2'h0;
      else
         wait_reg <= (nvm_rd_ack || !nvm_rd_req) ? 2'h0 : wait_reg + 2'h1;
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         last_reg <= 8'h5a;
      else if (nvm_rd_ack)
         last_reg <= nvm_rd_data;
   end
endmodule

// file: tb/bgp_gauge_tb.sv
// Self-checking bench for the battery gauge parameter logic
`timescale 1ns/1ps
module bgp_gauge_tb;
   typedef struct packed {logic em; logic [7:0] rs; logic [7:0] t; logic [15:0] dc; logic [15:0] fc; logic [15:0] ef;} bgp_row_s;
   logic clk = 1'b0, reset = 1'b1, slow = 1'b1, energy_mode = 1'b0, discharging = 1'b0, fast_allowed = 1'b0;
   logic fast_term = 1'b0, nvm_rd_req, nvm_rd_ack, params_loaded, full_capacity_update, charge_suspend;
   logic [6:0] nvm_addr;
   logic [7:0] nvm_rd_data, rsoc = 8'h32;
   logic signed [7:0] temp_c = 8'h14;
   logic [15:0] pack_mv = 16'h2ee0, rem_cap = 16'h01f4, disch = 16'h0000;
   logic [15:0] filt, dcap, fcc, edv_lo, edv_mid, edv_hi, sdr, llc, eff, chg_v, chg_i;
   logic [2:0] mid_mm;
   int miscompares = 0, checks_done = 0, pulses = 0;
   bgp_row_s rows [7] = '{'{1'b0, 8'h32, 8'h14, 16'h0fa0, 16'h0ed8, 16'h1e50},
      '{1'b1, 8'h32, 8'h14, 16'h10e0, 16'h1008, 16'h1e50}, '{1'b0, 8'h60, 8'h14, 16'h0fa0, 16'h0ed8, 16'h1e50},
      '{1'b0, 8'h64, 8'h14, 16'h0fa0, 16'h0ed8, 16'h1d10}, '{1'b0, 8'h32, 8'h23, 16'h0fa0, 16'h0ed8, 16'h1d88},
      '{1'b0, 8'h64, 8'h23, 16'h0fa0, 16'h0ed8, 16'h1c48}, '{1'b0, 8'h32, 8'h1a, 16'h0fa0, 16'h0ed8, 16'h1e3c}};
   bgp_gauge u_dut (.clk(clk), .reset(reset), .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
      .nvm_rd_data(nvm_rd_data), .nvm_rd_ack(nvm_rd_ack), .energy_mode(energy_mode), .pack_voltage_mv(pack_mv),
      .load_current_ma(16'sh0000), .temperature_c(temp_c), .relative_charge_pct(rsoc), .remaining_capacity(rem_cap),
      .discharged_mah(disch), .discharging(discharging), .charging(1'b0), .fast_charge_allowed(fast_allowed),
      .fast_charge_terminated(fast_term), .params_loaded(params_loaded), .filter_threshold_uv(filt),
      .design_capacity(dcap), .full_charge_capacity(fcc), .full_capacity_update(full_capacity_update),
      .end_voltage_lowest(edv_lo), .end_voltage_middle(edv_mid), .end_voltage_highest(edv_hi),
      .midrange_mismatch(mid_mm), .self_discharge_per_day(sdr), .light_load_current(llc),
      .charge_efficiency(eff), .charging_voltage(chg_v), .charge_suspend(charge_suspend), .charging_current(chg_i));
   bgp_nvm_model u_nvm (.clk(clk), .reset(reset), .slow(slow), .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
      .nvm_rd_data(nvm_rd_data), .nvm_rd_ack(nvm_rd_ack));
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      if (full_capacity_update === 1'b1)
         pulses++;
   end
   task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      chk16(name, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put16(input int a, input logic [15:0] v);
      u_nvm.mem[a] = v[7:0];
      u_nvm.mem[a + 1] = v[15:8];
   endtask
   task automatic do_reset(input logic s);
      @(posedge clk);
      reset <= 1'b1;
      slow <= s;
      cyc(1);
      chk1("nvm_rd_req", 1'b1, nvm_rd_req);
      chk16("charging_current", 16'h0000, chg_i);
      repeat (11) @(posedge clk);
      reset <= 1'b0;
      cyc(20);
      chk16("filter_threshold_uv", 16'h0000, filt);
      for (int i = 0; i < 2000 && params_loaded !== 1'b1; i++)
         cyc(1);
      chk1("params_loaded", 1'b1, params_loaded);
      chk1("charge_suspend", 1'b0, charge_suspend);
   endtask
   task automatic drv(input logic [15:0] p, input logic f, input logic t);
      @(posedge clk);
      pack_mv <= p;
      fast_allowed <= f;
      fast_term <= t;
      cyc(3);
   endtask
   task automatic print_verdict;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      for (int a = 0; a < 128; a++)
         u_nvm.mem[a] = 8'h00;
      put16(8'h0a, 16'h3138); put16(8'h12, 16'h2a30); put16(8'h1a, 16'h07d0); put16(8'h1c, 16'h0064);
      put16(8'h1e, 16'h012c); put16(8'h38, 16'h0ed8); put16(8'h3a, 16'h0fa0); put16(8'h6c, 16'hd314);
      put16(8'h6e, 16'hcf2c); put16(8'h70, 16'hcb44); put16(8'h72, 16'h251c); put16(8'h74, 16'h2710);
      put16(8'h78, 16'h2904); put16(8'h52, 16'hcb2d); put16(8'h54, 16'h6412); put16(8'h64, 16'h50a0);
      u_nvm.mem[8'h2b] = 8'h40; u_nvm.mem[8'h48] = 8'h32; u_nvm.mem[8'h4d] = 8'he1; u_nvm.mem[8'h63] = 8'h20;
      do_reset(1'b1);
      chk16("filter_threshold_uv", 16'h0032, filt);
      chk16("self_discharge_per_day", 16'h0063, sdr);
      chk16("light_load_current", 16'h0afc, llc);
      chk16("charging_voltage", 16'h3138, chg_v);
      chk16("end_voltage_lowest", 16'h251c, edv_lo);
      chk16("end_voltage_middle", 16'h2710, edv_mid);
      chk16("end_voltage_highest", 16'h2904, edv_hi);
      foreach (rows[i])
      begin
         @(posedge clk);
         energy_mode <= rows[i].em;
         rsoc <= rows[i].rs;
         temp_c <= rows[i].t;
         cyc(3);
         chk16("design_capacity", rows[i].dc, dcap);
         chk16("full_charge_capacity", rows[i].fc, fcc);
         chk16("charge_efficiency", rows[i].ef, eff);
      end
      drv(16'h2ee0, 1'b1, 1'b0);
      chk16("charging_current", 16'h07d0, chg_i);
      chk16("midrange_mismatch", 16'h0001, {13'h0000, mid_mm});
      drv(16'h2ee0, 1'b0, 1'b0);
      chk16("charging_current", 16'h0000, chg_i);
      drv(16'h251c, 1'b1, 1'b0);
      chk16("charging_current", 16'h07d0, chg_i);
      drv(16'h251b, 1'b1, 1'b0);
      chk16("charging_current", 16'h012c, chg_i);
      drv(16'h3459, 1'b1, 1'b0);
      chk1("charge_suspend", 1'b1, charge_suspend);
      chk16("charging_current", 16'h0000, chg_i);
      drv(16'h3458, 1'b1, 1'b0);
      chk1("charge_suspend", 1'b0, charge_suspend);
      drv(16'h2ee0, 1'b1, 1'b1);
      chk16("charging_current", 16'h0000, chg_i);
      drv(16'h2ee0, 1'b1, 1'b0);
      chk16("charging_current", 16'h0064, chg_i);
      @(posedge clk);
      discharging <= 1'b1;
      disch <= 16'h0dac;
      drv(16'h2710, 1'b0, 1'b0);
      chk16("update_pulses", 16'h0000, pulses[15:0]);
      @(posedge clk);
      rem_cap <= 16'h0e74;
      drv(16'h2ee0, 1'b0, 1'b0);
      drv(16'h2710, 1'b0, 1'b0);
      chk16("update_pulses", 16'h0001, pulses[15:0]);
      chk16("full_charge_capacity", 16'h0dac, fcc);
      u_nvm.mem[8'h3f] = 8'h14;
      do_reset(1'b0);
      @(posedge clk);
      rsoc <= 8'h64;
      temp_c <= 8'h23;
      cyc(3);
      chk16("charge_efficiency", 16'h1e50, eff);
      chk16("end_voltage_lowest", 16'h23a3, edv_lo);
      chk16("end_voltage_middle", 16'h2404, edv_mid);
      chk16("end_voltage_highest", 16'h2486, edv_hi);
      print_verdict();
   end
   initial
   begin
      #400000;
      miscompares++;
      print_verdict();
   end
endmodule
